// *** dv/tb.sv ***
`timescale 1ns/100ps
module tb;
  logic clk, rst, in_valid, out_valid, pkt_start, transmit_error_flag, irq, reg_wr, reg_rd;
  logic [31:0] in_data, reg_wdata, reg_rdata;
  logic [3:0] reg_addr, last_be;
  tcw_pkg::tcw_word_t out_word;
  tcw_pkg::tcw_pkt_ctl_t pkt_ctl;
  int err_total = 0;
  int total_checks = 0;
  int n_out = 0;
  tcw_host u_host (.clk(clk), .in_valid(in_valid), .in_data(in_data));
  tcw_checker u_tcw_checker (.clk(clk), .rst(rst), .in_valid(in_valid), .in_data(in_data),
    .out_valid(out_valid), .out_word(out_word), .pkt_start(pkt_start), .pkt_ctl(pkt_ctl),
    .transmit_error_flag(transmit_error_flag), .irq(irq), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (out_valid) begin
      n_out <= n_out + 1;
      last_be <= out_word.be;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata);
  endtask : rd
  // One buffer, then the kept word count, last lane mask and error level
  task automatic pkt(input logic [31:0] a, b, input int n, input logic [3:0] be,
      input logic err);
    int n0;
    n0 = n_out;
    u_host.xfer(a, b);
    repeat (3) @(posedge clk);
    chk("word count", n, n_out - n0);
    chk("lane mask", {28'h0, be}, {28'h0, last_be});
    chk("error flag", {31'h0, err}, {31'h0, transmit_error_flag});
  endtask : pkt
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h1);
    rd(4'h2, 32'h0);
    wr(4'h4, 32'h1);
    rd(4'h4, 32'h1);
    pkt(32'h01003005, 32'hbeef0005, 2, 4'h1, 1'b0);
    rd(4'hc, 32'h0000beef);
    pkt(32'h02053006, 32'h12343006, 2, 4'h7, 1'b0);
    pkt(32'h00002004, 32'h00000009, 1, 4'hf, 1'b0);
    pkt(32'h00001005, 32'h00000009, 2, 4'h1, 1'b0);
    pkt(32'h00003004, 32'h00000005, 1, 4'hf, 1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(4'h0, 32'h7);
    wr(4'h4, 32'h0);
    #1;
    chk("error clear", 32'h0, {31'h0, transmit_error_flag});
    pkt(32'h00002004, 32'h00010008, 1, 4'hf, 1'b0);
    pkt(32'h00001004, 32'h00020008, 1, 4'hf, 1'b1);
    chk("masked irq", 32'h0, {31'h0, irq});
    rd(4'h0, 32'h3);
    pkt(32'h80003004, 32'h00000004, 1, 4'hf, 1'b1);
    rd(4'h0, 32'h7);
    pkt(32'h00002004, 32'h00000008, 1, 4'hf, 1'b1);
    rd(4'hc, 32'h00010000);
    wr(4'h8, 32'h3);
    rd(4'hc, 32'h0);
    rd(4'h8, 32'h1);
    results();
  end
endmodule : tb
bind tcw_checker tcw_checker_props u_props (.clk(clk), .rst(rst), .in_valid(in_valid),
  .in_data(in_data), .out_valid(out_valid), .out_word(out_word), .pkt_start(pkt_start),
  .pkt_ctl(pkt_ctl), .transmit_error_flag(transmit_error_flag), .irq(irq),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

// *** dv/tcw_checker_props.sv ***
`timescale 1ns/100ps
module tcw_checker_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  input wire logic out_valid,
  input wire tcw_pkg::tcw_word_t out_word,
  input wire logic pkt_start,
  input wire tcw_pkg::tcw_pkt_ctl_t pkt_ctl,
  input wire logic transmit_error_flag,
  input wire logic irq,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_err_sticky: assert property (
    transmit_error_flag && !(reg_wr && reg_addr == 4'h0) |=> transmit_error_flag)
    else $error("error flag dropped");
  a_err_cause: assert property (
    $rose(transmit_error_flag) |-> $past(in_valid) || $past(in_valid, 2))
    else $error("error flag without input");
  a_tag_copy: assert property (
    pkt_start |-> pkt_ctl.tag == $past(in_data[31:16])) else $error("tag mismatch");
  a_crc_ctl: assert property (
    pkt_start |-> pkt_ctl.append_crc == (!$past(in_data[13]) || $past(in_data[12])))
    else $error("crc control wrong");
  a_pad_ctl: assert property (
    pkt_start |-> pkt_ctl.pad_short == !$past(in_data[12])) else $error("pad control wrong");
  a_start_cause: assert property (
    pkt_start |-> $past(in_valid)) else $error("start without word");
  a_ctl_hold: assert property (
    !pkt_start |-> $stable(pkt_ctl)) else $error("control changed");
  a_out_cause: assert property (
    out_valid |-> $past(in_valid)) else $error("output without input");
  a_word_hold: assert property (
    !out_valid |-> $stable(out_word)) else $error("word changed");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside its cycle");
  c_start: cover property (pkt_start);
  c_err: cover property ($rose(transmit_error_flag));
  c_eop: cover property (out_valid && out_word.eop);
endmodule : tcw_checker_props

// *** dv/tcw_host.sv ***
`timescale 1ns/100ps
module tcw_host (
  input wire logic clk,
  output logic in_valid,
  output logic [31:0] in_data
);
  initial begin
    in_valid = 1'b0;
    in_data = 32'h0;
  end
  // Padding dwords carry data too, so a missed strip shows up
  task automatic xfer(input logic [31:0] a, input logic [31:0] b);
    int n;
    int g;
    n = (int'(a[20:16]) + int'(a[10:0]) + 3) / 4;
    g = (a[25:24] == 2'h1) ? 4 : (a[25:24] == 2'h2) ? 8 : 1;
    n = (n + g - 1) / g * g;
    @(posedge clk);
    in_valid <= 1'b1;
    in_data <= a;
    @(posedge clk);
    in_data <= b;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      in_data <= {4{i[7:0] + 8'h11}};
    end
    @(posedge clk);
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask : xfer
endmodule : tcw_host

// *** inc/tcw_pkg.sv ***
package tcw_pkg;

  typedef struct packed {
    logic irq_on_done;
    logic [4:0] rsvd_hi;
    logic [1:0] end_align;
    logic [2:0] rsvd_mid;
    logic [4:0] start_offset;
    logic [1:0] rsvd_lo;
    logic first_seg;
    logic last_seg;
    logic rsvd_b11;
    logic [10:0] buf_size;
  } tcw_cmd_a_t;

  typedef struct packed {
    logic [15:0] tag;
    logic [1:0] rsvd_hi;
    logic crc_dis;
    logic pad_dis;
    logic rsvd_b11;
    logic [10:0] pkt_len;
  } tcw_cmd_b_t;

  typedef struct packed {
    logic [15:0] tag;
    logic append_crc;
    logic pad_short;
  } tcw_pkt_ctl_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] be;
    logic sop;
    logic eop;
  } tcw_word_t;

  typedef enum logic [1:0] {
    TCW_ALIGN_4,
    TCW_ALIGN_16,
    TCW_ALIGN_32,
    TCW_ALIGN_RSVD
  } tcw_align_t;

  typedef enum {TCW_S_CMD_A, TCW_S_CMD_B, TCW_S_DATA} tcw_state_t;

  localparam logic [3:0] TCW_OFF_STATUS = 4'h0;
  localparam logic [3:0] TCW_OFF_MASK = 4'h4;
  localparam logic [3:0] TCW_OFF_CTRL = 4'h8;
  localparam logic [3:0] TCW_OFF_TAG = 4'hc;
  localparam int TCW_ST_ERR = 0;
  localparam int TCW_ST_DONE = 1;
  localparam int TCW_ST_BUF = 2;
  localparam int TCW_CTRL_EN = 0;
  localparam int TCW_CTRL_RESYNC = 1;
  localparam logic [2:0] TCW_STATUS_RST = 3'h0;
  localparam logic [2:0] TCW_MASK_RST = 3'h0;
  localparam logic [1:0] TCW_CTRL_RST = 2'h1;

endpackage : tcw_pkg

// *** src/tcw_checker.sv ***
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module tcw_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  output logic out_valid,
  output tcw_pkg::tcw_word_t out_word,
  output logic pkt_start,
  output tcw_pkg::tcw_pkt_ctl_t pkt_ctl,
  output logic transmit_error_flag,
  output logic irq,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // Words needed for the whole buffer, rounded to the end alignment
  function automatic logic [9:0] align_words(input logic [9:0] w, input logic [1:0] code);
    logic [9:0] r;
    r = w;
    case (code)
      tcw_pkg::TCW_ALIGN_16: r = 10'((w + 10'h3) & 10'h3fc);
      tcw_pkg::TCW_ALIGN_32: r = 10'((w + 10'h7) & 10'h3f8);
      default: r = w;
    endcase
    return r;
  endfunction : align_words

  tcw_pkg::tcw_state_t state_q, state_d;
  tcw_pkg::tcw_cmd_a_t a_q;
  tcw_pkg::tcw_cmd_b_t b_q;
  logic [9:0] idx_q;
  logic [9:0] skip_q;
  logic [9:0] end_q;
  logic [9:0] total_q;
  logic in_pkt_q;
  logic [11:0] sum_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [1:0] ctrl_q;
  logic [15:0] last_tag_q;

  // Command A and command B decoding
  tcw_pkg::tcw_cmd_a_t a_in;
  tcw_pkg::tcw_cmd_b_t b_in;
  assign a_in = tcw_pkg::tcw_cmd_a_t'(in_data);
  assign b_in = tcw_pkg::tcw_cmd_b_t'(in_data);
  wire [11:0] span = {1'b0, a_in.buf_size} + {7'h0, a_in.start_offset};
  wire [11:0] span_r = 12'(span + 12'h3);
  wire [9:0] used_words = span_r[11:2];
  wire [9:0] all_words = align_words(used_words, a_in.end_align);
  wire [9:0] skip_words = {7'h0, a_in.start_offset[4:2]};

  wire enabled = ctrl_q[tcw_pkg::TCW_CTRL_EN];
  wire resync = reg_wr && reg_addr == tcw_pkg::TCW_OFF_CTRL
                && reg_wdata[tcw_pkg::TCW_CTRL_RESYNC];
  wire take = in_valid && enabled;
  wire take_a = take && state_q == tcw_pkg::TCW_S_CMD_A;
  wire take_b = take && state_q == tcw_pkg::TCW_S_CMD_B;
  wire take_d = take && state_q == tcw_pkg::TCW_S_DATA;
  wire last_word = idx_q == 10'(total_q - 10'h1);

  // Packet accounting done when the second word of a buffer arrives; the buffer-done event on its last data word
  wire [11:0] sum_add = 12'(sum_q + {1'b0, a_q.buf_size});
  wire [11:0] sum_new = a_q.first_seg ? {1'b0, a_q.buf_size} : sum_add;
  wire orphan = !a_q.first_seg && !in_pkt_q;
  wire b_differs = !a_q.first_seg && in_pkt_q && b_in != b_q;
  wire len_bad = a_q.last_seg && sum_new != {1'b0, b_in.pkt_len};
  wire err_ev = take_b && (orphan || b_differs || len_bad);
  wire done_ev = take_b && a_q.last_seg;
  wire buf_ev = take_d && last_word && a_q.irq_on_done;
  wire [2:0] events = {buf_ev, done_ev, err_ev};

  // Per packet frame controls, taken from the opening segment
  tcw_pkg::tcw_pkt_ctl_t ctl_new;
  assign ctl_new.tag = b_in.tag;
  assign ctl_new.append_crc = !b_in.crc_dis || b_in.pad_dis;
  assign ctl_new.pad_short = !b_in.pad_dis;

  // Data word strip: leading offset dwords and trailing alignment dwords never leave
  wire in_range = idx_q >= skip_q && idx_q < end_q && a_q.buf_size != 11'h0;
  wire is_first = idx_q == skip_q;
  wire is_last = idx_q == 10'(end_q - 10'h1);
  wire [11:0] stop_byte = 12'({1'b0, a_q.buf_size} + {7'h0, a_q.start_offset} - 12'h1);
  wire [3:0] be_head = 4'(4'hf << a_q.start_offset[1:0]);
  wire [3:0] be_tail = 4'(4'hf >> (2'h3 - stop_byte[1:0]));
  wire [3:0] be_word = (is_first ? be_head : 4'hf) & (is_last ? be_tail : 4'hf);
  tcw_pkg::tcw_word_t word_d;
  assign word_d.data = in_data;
  assign word_d.be = be_word;
  assign word_d.sop = is_first && a_q.first_seg;
  assign word_d.eop = is_last && a_q.last_seg;

  // Register file
  wire wr_status = reg_wr && reg_addr == tcw_pkg::TCW_OFF_STATUS;
  wire wr_mask = reg_wr && reg_addr == tcw_pkg::TCW_OFF_MASK;
  wire wr_ctrl = reg_wr && reg_addr == tcw_pkg::TCW_OFF_CTRL;
  wire [2:0] st_clr = wr_status ? reg_wdata[2:0] : 3'h0;
  // A new event beats a clear landing in the same cycle
  wire [2:0] status_d = (status_q & ~st_clr) | events;
  wire [31:0] rd_mux =
      reg_addr == tcw_pkg::TCW_OFF_STATUS ? {29'h0, status_q} :
      reg_addr == tcw_pkg::TCW_OFF_MASK ? {29'h0, mask_q} :
      reg_addr == tcw_pkg::TCW_OFF_CTRL ? {31'h0, ctrl_q[tcw_pkg::TCW_CTRL_EN]} :
      reg_addr == tcw_pkg::TCW_OFF_TAG ? {15'h0, in_pkt_q, last_tag_q} : 32'h0;

  always_comb begin
    state_d = state_q;
    case (state_q)
      tcw_pkg::TCW_S_CMD_A: begin
        if (take) begin
          state_d = tcw_pkg::TCW_S_CMD_B;
        end
      end
      tcw_pkg::TCW_S_CMD_B: begin
        if (take) begin
          state_d = total_q == 10'h0 ? tcw_pkg::TCW_S_CMD_A : tcw_pkg::TCW_S_DATA;
        end
      end
      tcw_pkg::TCW_S_DATA: begin
        if (take && last_word) begin
          state_d = tcw_pkg::TCW_S_CMD_A;
        end
      end
      default: state_d = tcw_pkg::TCW_S_CMD_A;
    endcase
    if (resync) begin
      state_d = tcw_pkg::TCW_S_CMD_A;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= tcw_pkg::TCW_S_CMD_A;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      a_q <= '0;
      skip_q <= 10'h0;
      end_q <= 10'h0;
      total_q <= 10'h0;
    end else if (take_a) begin
      a_q <= a_in;
      skip_q <= skip_words;
      end_q <= used_words;
      total_q <= all_words;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || take_b || resync) begin
      idx_q <= 10'h0;
    end else if (take_d) begin
      idx_q <= 10'(idx_q + 10'h1);
    end
  end

  // Packet context
  always_ff @(posedge clk) begin
    if (rst || resync) begin
      in_pkt_q <= 1'b0;
      sum_q <= 12'h0;
      b_q <= '0;
    end else if (take_b) begin
      in_pkt_q <= !a_q.last_seg && (a_q.first_seg || in_pkt_q);
      sum_q <= sum_new;
      if (a_q.first_seg) begin
        b_q <= b_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pkt_start <= 1'b0;
      pkt_ctl <= '0;
      last_tag_q <= 16'h0;
    end else begin
      pkt_start <= take_b && a_q.first_seg;
      if (take_b && a_q.first_seg) begin
        pkt_ctl <= ctl_new;
      end
      if (done_ev) begin
        last_tag_q <= b_in.tag;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_word <= '0;
    end else begin
      out_valid <= take_d && in_range;
      if (take_d && in_range) begin
        out_word <= word_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= tcw_pkg::TCW_STATUS_RST;
      mask_q <= tcw_pkg::TCW_MASK_RST;
      ctrl_q <= tcw_pkg::TCW_CTRL_RST;
      transmit_error_flag <= 1'b0;
      irq <= 1'b0;
      reg_rdata <= 32'h0;
    end else begin
      status_q <= status_d;
      if (wr_mask) begin
        mask_q <= reg_wdata[2:0];
      end
      if (wr_ctrl) begin
        ctrl_q <= {1'b0, reg_wdata[tcw_pkg::TCW_CTRL_EN]};
      end
      transmit_error_flag <= status_d[tcw_pkg::TCW_ST_ERR];
      irq <= |(status_d & mask_q);
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

endmodule : tcw_checker
